// ==== inc/sync_regs_pkg.sv ====
// constants for the sync control and upper test pattern register slice
// assumes a byte-wide register port decoded by the serial control front end
package sync_regs_pkg;
  // register addresses
  localparam logic [7:0] addr_pattern3_low = 8'h1d;
  localparam logic [7:0] addr_pattern3_high = 8'h1e;
  localparam logic [7:0] addr_pattern4_low = 8'h1f;
  localparam logic [7:0] addr_pattern4_high = 8'h20;
  localparam logic [7:0] addr_signature_low = 8'h24;
  localparam logic [7:0] addr_signature_high = 8'h25;
  localparam logic [7:0] addr_sync_control = 8'h3a;
  // reset values
  localparam logic [7:0] pattern_reset = 8'h00;
  localparam logic [7:0] sync_control_reset = 8'h00;
  localparam logic [7:0] read_data_reset = 8'h00;
  localparam logic pulse_reset = 1'b0;
  // sync control field positions
  localparam int master_enable_bit = 0;
  localparam int divider_enable_bit = 1;
  localparam int one_shot_bit = 2;
  localparam logic [7:0] sync_control_mask = 8'h07;
endpackage

// ==== rtl/sync_regs.sv ====
// sync control, upper user test patterns and self-test signature registers
// assumes the serial port front end presents byte accesses synchronous to clk
// and that the sync pulse input is already synchronous to clk
module sync_regs (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // self-test engine result
  input wire logic [15:0] signature,
  // sync path
  input wire logic sync_in,
  output logic divider_sync,
  output logic sync_buffer_enable,
  // pattern values to the test pattern generator
  output logic [15:0] pattern3,
  output logic [15:0] pattern4
);

  ////////////////////////////////////////////////////////////////////////////
  // state and helper signals

  // pattern three bytes; each byte is its own register so the host may
  // rewrite one half without disturbing the other
  logic [7:0] p3l_reg; // pattern three low byte
  logic [7:0] p3l_next; // next value of the low byte
  logic [7:0] p3h_reg; // pattern three high byte
  logic [7:0] p3h_next; // next value of the high byte

  // pattern four bytes, same arrangement as pattern three
  logic [7:0] p4l_reg; // pattern four low byte
  logic [7:0] p4l_next; // next value of the low byte
  logic [7:0] p4h_reg; // pattern four high byte
  logic [7:0] p4h_next; // next value of the high byte

  // sync control: only the three defined bits are stored, the open bits
  // cost no flops and simply read back as zero
  logic [2:0] ctrl_reg; // sync control bits 2..0
  logic [2:0] ctrl_next; // next value of the sync control bits

  // registered divider sync pulse; the extra flop keeps the output free of
  // glitches at the price of one cycle of latency
  logic pulse_reg; // divider sync pulse
  logic pulse_next; // next value of the pulse
  logic gate; // a sync pulse is allowed through this cycle
  logic shot_taken; // the aligning pulse of one-shot mode passes now

  // read data, held until the next read so a slow host can pick it up
  logic [7:0] rdata_reg; // read data
  logic [7:0] rdata_next; // next read data

  // decoded write strobes, one per writable register
  logic wr_p3l; // write to pattern three low byte
  logic wr_p3h; // write to pattern three high byte
  logic wr_p4l; // write to pattern four low byte
  logic wr_p4h; // write to pattern four high byte
  logic wr_ctrl; // write to sync control

  ////////////////////////////////////////////////////////////////////////////
  // address decoding

  // true when an address selects the given register
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction

  // true when the address is one of the registers of this slice
  function automatic logic mapped(input logic [7:0] a);
    mapped = addr_is(a, sync_regs_pkg::addr_pattern3_low) ||
             addr_is(a, sync_regs_pkg::addr_pattern3_high) ||
             addr_is(a, sync_regs_pkg::addr_pattern4_low) ||
             addr_is(a, sync_regs_pkg::addr_pattern4_high) ||
             addr_is(a, sync_regs_pkg::addr_signature_low) ||
             addr_is(a, sync_regs_pkg::addr_signature_high) ||
             addr_is(a, sync_regs_pkg::addr_sync_control);
  endfunction

  // write strobes; the signature addresses get none, so host writes to
  // them fall on the floor
  assign wr_p3l = reg_write && addr_is(reg_addr, sync_regs_pkg::addr_pattern3_low);
  assign wr_p3h = reg_write && addr_is(reg_addr, sync_regs_pkg::addr_pattern3_high);
  assign wr_p4l = reg_write && addr_is(reg_addr, sync_regs_pkg::addr_pattern4_low);
  assign wr_p4h = reg_write && addr_is(reg_addr, sync_regs_pkg::addr_pattern4_high);
  assign wr_ctrl = reg_write && addr_is(reg_addr, sync_regs_pkg::addr_sync_control);

  ////////////////////////////////////////////////////////////////////////////
  // pattern bytes

  // next values; a byte changes only on a write to its own address
  always_comb begin
    p3l_next = p3l_reg;
    p3h_next = p3h_reg;
    p4l_next = p4l_reg;
    p4h_next = p4h_reg;
    // low byte of pattern three
    if (wr_p3l) begin
      p3l_next = reg_wdata;
    end
    // high byte of pattern three
    if (wr_p3h) begin
      p3h_next = reg_wdata;
    end
    // low byte of pattern four
    if (wr_p4l) begin
      p4l_next = reg_wdata;
    end
    // high byte of pattern four
    if (wr_p4h) begin
      p4h_next = reg_wdata;
    end
  end

  // pattern byte registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      p3l_reg <= sync_regs_pkg::pattern_reset;
      p3h_reg <= sync_regs_pkg::pattern_reset;
      p4l_reg <= sync_regs_pkg::pattern_reset;
      p4h_reg <= sync_regs_pkg::pattern_reset;
    end else begin
      p3l_reg <= p3l_next;
      p3h_reg <= p3h_next;
      p4l_reg <= p4l_next;
      p4h_reg <= p4h_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync control and divider pulse

  // next values of the control bits and the pulse
  always_comb begin
    ctrl_next = ctrl_reg;
    // sync passes only with master and divider enables both set
    gate = sync_in && ctrl_reg[sync_regs_pkg::master_enable_bit] &&
           ctrl_reg[sync_regs_pkg::divider_enable_bit];
    // in one-shot mode this passing pulse is the aligning one
    shot_taken = gate && ctrl_reg[sync_regs_pkg::one_shot_bit];
    // every passing pulse reaches the divider, one cycle later
    pulse_next = gate;
    // host write replaces all three bits; open bits are dropped
    if (wr_ctrl) begin
      ctrl_next = reg_wdata[2:0];
    end
    // hardware wins over a same-cycle host write, otherwise a write landing
    // with the aligning pulse could re-arm the divider behind the host's back
    if (shot_taken) begin
      ctrl_next[sync_regs_pkg::divider_enable_bit] = 1'b0;
    end
  end

  // control and pulse registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= sync_regs_pkg::sync_control_reset[2:0];
      pulse_reg <= sync_regs_pkg::pulse_reset;
    end else begin
      ctrl_reg <= ctrl_next;
      pulse_reg <= pulse_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  // read mux; the signature is taken live, so a read during a self-test run
  // may catch a half-updated word, which the host must avoid
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_read) begin
      case (reg_addr)
        // pattern bytes read back as written
        sync_regs_pkg::addr_pattern3_low: begin
          rdata_next = p3l_reg;
        end
        sync_regs_pkg::addr_pattern3_high: begin
          rdata_next = p3h_reg;
        end
        sync_regs_pkg::addr_pattern4_low: begin
          rdata_next = p4l_reg;
        end
        sync_regs_pkg::addr_pattern4_high: begin
          rdata_next = p4h_reg;
        end
        // signature halves, read only
        sync_regs_pkg::addr_signature_low: begin
          rdata_next = signature[7:0];
        end
        sync_regs_pkg::addr_signature_high: begin
          rdata_next = signature[15:8];
        end
        // control, open bits read zero; a cleared divider enable shows here
        sync_regs_pkg::addr_sync_control: begin
          rdata_next = {5'h00, ctrl_reg};
        end
        // unmapped addresses read zero
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // read data register, held between reads
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= sync_regs_pkg::read_data_reset;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // register port answers
  assign reg_rdata = rdata_reg;
  assign reg_hit = mapped(reg_addr) && (reg_read || reg_write);

  // sync path; the buffer is powered only with master enable set
  assign divider_sync = pulse_reg;
  assign sync_buffer_enable = ctrl_reg[sync_regs_pkg::master_enable_bit];

  // patterns as {high byte, low byte}
  assign pattern3 = {p3h_reg, p3l_reg};
  assign pattern4 = {p4h_reg, p4l_reg};

endmodule

// ==== verif/host_model.sv ====
// host side of the byte register port
// assumes single cycle strobes taken on the rising edge of clk
module host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic wr_en, rd_en,
  output logic [7:0] addr, wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // bus idle from time zero, strobes, address and write data all zero
  initial {wr_en, rd_en, addr, wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) {wr_en, addr, wdata} <= {1'b1, a, d};
    @(posedge clk) wr_en <= 0;
    #1;
  endtask
  // read data is taken just after the edge that took the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) {rd_en, addr} <= {1'b1, a};
    @(posedge clk) rd_en <= 0;
    #1 d = rdata;
  endtask
endmodule

// ==== verif/sync_regs_sva.sv ====
// checker for the sync_regs register port and sync path
// assumes it is bound to every sync_regs instance
module sync_regs_sva (
  // watched ports
  input wire logic clk, resetn, reg_write, reg_read, reg_hit,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [15:0] signature, pattern3, pattern4,
  input wire logic sync_in, divider_sync, sync_buffer_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  // last control write armed one-shot with both enables
  logic shot_cfg;
  // the aligning pulse of that arming has gone out
  logic shot_seen;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shot_cfg <= 1'b0;
      shot_seen <= 1'b0;
    end else if (reg_write && reg_addr == 8'h3a) begin
      shot_cfg <= (reg_wdata[2:0] == 3'h7);
      shot_seen <= 1'b0;
    end else if (shot_cfg && divider_sync) begin
      shot_seen <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // a byte write to one address
  sequence wr_at(a); reg_write && reg_addr == a; endsequence
  sequence shot_done; shot_seen; endsequence
  sequence ctrl_read; reg_read && reg_addr == 8'h3a; endsequence
  a_low_byte: assert property (wr_at(8'h1d) |=> pattern3[7:0] == $past(reg_wdata))
    else $error("pattern3 low byte not written");
  a_high_byte: assert property (wr_at(8'h20) |=> pattern4[15:8] == $past(reg_wdata))
    else $error("pattern4 high byte not written");
  a_master_gate: assert property (!sync_buffer_enable |=> !divider_sync)
    else $error("sync passed with buffer off");
  a_pulse_cause: assert property (divider_sync |-> $past(sync_in) && $past(sync_buffer_enable))
    else $error("divider sync without cause");
  a_sig_read: assert property (reg_read && reg_addr == 8'h25 |=> reg_rdata == $past(signature[15:8]))
    else $error("signature high byte wrong");
  a_one_shot_once: assert property (shot_done |-> !divider_sync)
    else $error("second pulse passed in one-shot mode");
  a_self_clear: assert property (shot_done ##0 ctrl_read |=> !reg_rdata[1])
    else $error("divider enable not cleared after one-shot");
  a_hit_mapped: assert property (ctrl_read |-> reg_hit)
    else $error("mapped read not flagged as hit");
  a_unmapped_zero: assert property (reg_read && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind sync_regs sync_regs_sva i_sync_regs_sva (.*);

// ==== verif/tb_sync_regs.sv ====
// self-checking bench for sync_regs
// assumes the host model owns the register port strobes
module tb_sync_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, sync_in = 0, wr_en, rd_en, hit, dsync, sbe;
  logic [15:0] signature = 16'h0000, p3, p4;
  logic [7:0] addr, wdata, rdata, d;
  int err_count = 0, num_checks = 0, pulses = 0, cycles = 0;
  initial forever #20 clk = ~clk;
  host_model i_host (.clk(clk), .rdata(rdata), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata));
  sync_regs i_sync_regs (.clk(clk), .resetn(resetn), .reg_write(wr_en), .reg_read(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_hit(hit), .signature(signature),
    .sync_in(sync_in), .divider_sync(dsync), .sync_buffer_enable(sbe), .pattern3(p3),
    .pattern4(p4));
  // count passed pulses; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (dsync === 1'b1) pulses <= pulses + 1;
    if (cycles == 3000) begin err_count++; conclude(); end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin $display("mismatch %s exp %h got %h", n, e, g); err_count++; end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", err_count, num_checks);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // each pattern byte lands in its own half
  task automatic t_patterns();
    for (int i = 0; i < 4; i++) i_host.wr(8'h1d + i, 8'h11 * (i + 1));
    chk("pattern3", 16'h2211, p3);
    chk("pattern4", 16'h4433, p4);
  endtask
  // signature ignores writes; an unmapped place reads zero
  task automatic t_signature();
    @(posedge clk) signature <= 16'h5aa5;
    i_host.wr(8'h24, 8'hff);
    i_host.rd(8'h24, d);
    chk("sig_low", 16'h00a5, {8'h00, d});
    i_host.rd(8'h30, d);
    chk("unmapped", 16'h0000, {8'h00, d});
  endtask
  // hold sync_in for n sampled edges
  task automatic pulse(input int n);
    pulses = 0;
    @(posedge clk) sync_in <= 1;
    repeat (n) @(posedge clk);
    sync_in <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // master enable gates, continuous mode, then one-shot with self-clear
  task automatic t_sync();
    i_host.wr(8'h3a, 8'h02);
    chk("buffer_off", 16'h0000, {15'h0000, sbe});
    pulse(2);
    chk("gated_off", 0, pulses);
    i_host.wr(8'h3a, 8'h03);
    chk("buffer_on", 16'h0001, {15'h0000, sbe});
    pulse(2);
    chk("continuous", 2, pulses);
    i_host.wr(8'h3a, 8'h07);
    pulse(3);
    chk("one_shot", 1, pulses);
    i_host.rd(8'h3a, d);
    chk("self_clear", 16'h0005, {8'h00, d});
    pulse(1);
    chk("ignored", 0, pulses);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1;
    t_patterns();
    t_signature();
    t_sync();
    conclude();
  end
endmodule
